// *** startup_address_and_reset_control.sv ***
// start-up sequencing: reset exit, address strap decode, jtag and brownout gating
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - flag a brownout whenever supply falls below 2.9 V detection level
// - brownout mode on: logs stay in SRAM, no flash writes
// - brownout seen with mode on: copy whole SRAM log into flash
// - brownout mode on: run-time counter survives resets and power-down
// - brownout mode off: run-time counter cleared after each reset
// - brownout mode optional, off unless config command turns it on
// - at power up bias both address pins and sample each with ADC
// - eight bins per pin; address is 12 times upper bin plus lower
// - each bin boundary is 1.25 times the previous one, except highest bin maximum BIN_B8 (12'hE00)
// - pin below lowest bin minimum gives address 126
// - pin above highest bin maximum gives address 126
// - jtag off by default, shared pins act as general I/O
// - jtag on at power up when config flash area is blank
// - jtag on when decoded address is 126; shared pins lost
// - four of six jtag pins usable as general I/O when jtag off
// - jtag mode runs system clock at 90 percent
// - jtag gives programming access only, no boundary scan
// - power-on reset holds until digital supply passes threshold
// - reset pin low beyond minimum pulse time holds device in reset
// - leave reset within 1 ms after reset pin rises
// - 20 ms init period on every reset exit, pwm low, others float
module startup_address_and_reset_control #(
  parameter int INIT_CYCLES = startup_ctrl_pkg::INIT_CYC,
  parameter int EXIT_CYCLES = startup_ctrl_pkg::RESET_EXIT_CYC,
  parameter logic [11:0] BIN_B0 = startup_ctrl_pkg::BIN_LOW_MIN,
  parameter logic [11:0] BIN_B1 = 12'h0FA,
  parameter logic [11:0] BIN_B2 = 12'h138,
  parameter logic [11:0] BIN_B3 = 12'h186,
  parameter logic [11:0] BIN_B4 = 12'h1E8,
  parameter logic [11:0] BIN_B5 = 12'h262,
  parameter logic [11:0] BIN_B6 = 12'h2FA,
  parameter logic [11:0] BIN_B7 = 12'h3B9,
  parameter logic [11:0] BIN_B8 = startup_ctrl_pkg::BIN_HIGH_MAX
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic supplyAboveThreshold,
  input wire logic resetPin,
  input wire logic supplyBelowBrownout,
  input wire logic brownoutModeCfg,
  input wire logic cfgFlashBlank,
  input wire logic adcDone,
  input wire logic [11:0] adcData,
  input wire logic logCopyDone,
  output logic adcStart,
  output logic adcSelUpper,
  output logic biasEnable,
  output logic deviceInReset,
  output logic initActive,
  output logic normalRun,
  output logic [6:0] busAddress,
  output logic jtagEnable,
  output logic sharedPinsGpio,
  output logic slowClock,
  output logic jtagScanEnable,
  output logic fastPwmLowHold,
  output logic generalPinsFloat,
  output logic brownoutFlag,
  output logic flashWriteAllowed,
  output logic logCopyStart,
  output logic runtimeClear
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [2:0] porSync_q, pinSync_q, boSync_q;
  logic porOk_q, pinHigh_q, boLow_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      porSync_q <= 3'h0;
      pinSync_q <= 3'h0;
      boSync_q <= 3'h0;
      porOk_q <= 1'b0;
      pinHigh_q <= 1'b0;
      boLow_q <= 1'b0;
    end else begin
      porSync_q <= {porSync_q[1:0], supplyAboveThreshold};
      pinSync_q <= {pinSync_q[1:0], resetPin};
      boSync_q <= {boSync_q[1:0], supplyBelowBrownout};
      if (porSync_q[1] == porSync_q[2]) porOk_q <= porSync_q[2];
      if (pinSync_q[1] == pinSync_q[2]) pinHigh_q <= pinSync_q[2];
      if (boSync_q[1] == boSync_q[2]) boLow_q <= boSync_q[2];
    end
  end

  // ****************************************
  // reset hold and exit
  // ****************************************
  logic [15:0] lowCnt_q;
  logic pinHold_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_q <= 16'h0000;
      pinHold_q <= 1'b0;
    end else if (pinHigh_q) begin
      lowCnt_q <= 16'h0000;
      pinHold_q <= 1'b0;
    end else if (lowCnt_q >= 16'(startup_ctrl_pkg::RESET_LOW_MIN_CYC)) begin
      pinHold_q <= 1'b1;
    end else begin
      lowCnt_q <= lowCnt_q + 16'h0001;
    end
  end

  wire holdReset = !porOk_q || pinHold_q;

  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_EXIT = 5'h02,
    ST_ADC = 5'h04,
    ST_INIT = 5'h08,
    ST_RUN = 5'h10
  } phase_e;
  phase_e state_q;
  logic [31:0] tmr_q;
  logic adcPhase_q;
  logic [2:0] binUp_q;
  logic badPin_q;
  logic latched_q;

  function automatic logic [3:0] binOf(input logic [11:0] v);
    logic [3:0] r;
    r = 4'h8;
    if (v < BIN_B0 || v > BIN_B8) r = 4'h8;
    else if (v < BIN_B1) r = 4'h0;
    else if (v < BIN_B2) r = 4'h1;
    else if (v < BIN_B3) r = 4'h2;
    else if (v < BIN_B4) r = 4'h3;
    else if (v < BIN_B5) r = 4'h4;
    else if (v < BIN_B6) r = 4'h5;
    else if (v < BIN_B7) r = 4'h6;
    else r = 4'h7;
    return r;
  endfunction : binOf

  wire [3:0] curBin = binOf(adcData);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_RESET;
      tmr_q <= 32'h0;
      adcPhase_q <= 1'b0;
      binUp_q <= 3'h0;
      badPin_q <= 1'b0;
      latched_q <= 1'b0;
      busAddress <= startup_ctrl_pkg::ADDR_FALLBACK;
      jtagEnable <= 1'b0;
      adcStart <= 1'b0;
      adcSelUpper <= 1'b0;
      biasEnable <= 1'b0;
    end else begin
      adcStart <= 1'b0;
      if (holdReset) begin
        state_q <= ST_RESET;
        tmr_q <= 32'h0;
        biasEnable <= 1'b0;
      end else begin
        unique case (state_q)
          ST_RESET: begin
            state_q <= ST_EXIT;
            tmr_q <= 32'h0;
          end
          ST_EXIT: begin
            if (tmr_q >= 32'(EXIT_CYCLES - 2)) begin
              tmr_q <= 32'h0;
              if (latched_q) begin
                state_q <= ST_INIT;
              end else begin
                state_q <= ST_ADC;
                biasEnable <= 1'b1;
                adcSelUpper <= 1'b1;
                adcStart <= 1'b1;
                adcPhase_q <= 1'b0;
                badPin_q <= 1'b0;
              end
            end else begin
              tmr_q <= tmr_q + 32'h1;
            end
          end
          ST_ADC: begin
            if (adcDone) begin
              if (!adcPhase_q) begin
                binUp_q <= curBin[2:0];
                badPin_q <= curBin[3];
                adcPhase_q <= 1'b1;
                adcSelUpper <= 1'b0;
                adcStart <= 1'b1;
              end else begin
                biasEnable <= 1'b0;
                latched_q <= 1'b1;
                state_q <= ST_INIT;
                if (badPin_q || curBin[3]) begin
                  busAddress <= startup_ctrl_pkg::ADDR_FALLBACK;
                  jtagEnable <= 1'b1;
                end else begin
                  busAddress <= 7'(binUp_q * startup_ctrl_pkg::ADDR_MULT + curBin[2:0]);
                  jtagEnable <= cfgFlashBlank;
                end
              end
            end
          end
          ST_INIT: begin
            if (tmr_q >= 32'(INIT_CYCLES - 1)) begin
              state_q <= ST_RUN;
            end else begin
              tmr_q <= tmr_q + 32'h1;
            end
          end
          ST_RUN: state_q <= ST_RUN;
        endcase
      end
    end
  end

  // ****************************************
  // pin and clock modes
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      deviceInReset <= 1'b1;
      initActive <= 1'b0;
      normalRun <= 1'b0;
      fastPwmLowHold <= 1'b1;
      generalPinsFloat <= 1'b1;
      sharedPinsGpio <= 1'b0;
      slowClock <= 1'b0;
      jtagScanEnable <= 1'b0;
    end else begin
      deviceInReset <= holdReset || state_q == ST_RESET || state_q == ST_EXIT;
      initActive <= state_q == ST_ADC || state_q == ST_INIT;
      normalRun <= state_q == ST_RUN && !holdReset;
      fastPwmLowHold <= state_q != ST_RUN || holdReset;
      generalPinsFloat <= state_q != ST_RUN || holdReset;
      sharedPinsGpio <= state_q == ST_RUN && !holdReset && !jtagEnable;
      slowClock <= jtagEnable;
      jtagScanEnable <= 1'b0;
    end
  end

  // ****************************************
  // brownout and logging
  // ****************************************
  logic boMode_q, copying_q, copied_q, cleared_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      boMode_q <= 1'b0;
      brownoutFlag <= 1'b0;
      flashWriteAllowed <= 1'b0;
      logCopyStart <= 1'b0;
      copying_q <= 1'b0;
      copied_q <= 1'b0;
      runtimeClear <= 1'b0;
      cleared_q <= 1'b0;
    end else begin
      boMode_q <= brownoutModeCfg;
      brownoutFlag <= boLow_q;
      logCopyStart <= 1'b0;
      flashWriteAllowed <= !boMode_q || copying_q;
      if (boMode_q && boLow_q && !copying_q && !copied_q) begin
        logCopyStart <= 1'b1;
        copying_q <= 1'b1;
      end else if (copying_q && logCopyDone) begin
        copying_q <= 1'b0;
        copied_q <= 1'b1;
      end
      if (!boLow_q && !copying_q) copied_q <= 1'b0;
      runtimeClear <= 1'b0;
      if (state_q == ST_INIT && !cleared_q) begin
        cleared_q <= 1'b1;
        runtimeClear <= !boMode_q;
      end else if (state_q == ST_RESET) begin
        cleared_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  fallback_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(latched_q) && (badPin_q || $past(curBin[3])) |-> busAddress == 7'h7E)
    else $error("fallback address not applied");
  jtag_on_126_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(latched_q) && busAddress == 7'h7E |-> jtagEnable)
    else $error("jtag not enabled at address 126");
  jtag_slow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    jtagEnable |=> slowClock)
    else $error("clock not slowed in jtag mode");
  gpio_shared_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sharedPinsGpio |-> !jtagEnable && normalRun)
    else $error("shared pins given to gpio with jtag on");
  addr_stable_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    latched_q && $past(latched_q) |-> $stable(busAddress) && $stable(jtagEnable))
    else $error("latched address changed");
  init_float_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    initActive |-> fastPwmLowHold && generalPinsFloat)
    else $error("pins released during init");
  no_flash_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $past(boMode_q) && !$past(copying_q) |-> !flashWriteAllowed)
    else $error("flash write in brownout mode");
  copy_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    logCopyStart |-> $past(boMode_q) && $past(boLow_q) ##1 copying_q)
    else $error("log copy without brownout");
  no_scan_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !jtagScanEnable)
    else $error("boundary scan enabled");
endmodule : startup_address_and_reset_control
`default_nettype wire

// *** startup_address_and_reset_control_test.sv ***
// self-checking bench for start-up address and reset control
`timescale 1ns/100ps
`default_nettype none
module startup_address_and_reset_control_test;
  logic sys_clk, rst_b, supplyAboveThreshold, resetPin, supplyBelowBrownout, brownoutModeCfg;
  logic cfgFlashBlank, adcDone, logCopyDone, adcStart, adcSelUpper, biasEnable, deviceInReset;
  logic initActive, normalRun, jtagEnable, sharedPinsGpio, slowClock, jtagScanEnable;
  logic fastPwmLowHold, generalPinsFloat, brownoutFlag, flashWriteAllowed, logCopyStart;
  logic runtimeClear;
  logic [11:0] adcData, upperCode, lowerCode;
  logic [6:0] busAddress;
  logic [3:0] lat;
  logic [11:0] bnd [9] = '{12'h0C8, 12'h0FA, 12'h138, 12'h186, 12'h1E8, 12'h262, 12'h2FA,
                           12'h3B9, 12'hE00};
  int error_cnt = 0;
  int n_checks = 0;
  int clears, initN, rstN;
  startup_address_and_reset_control #(.INIT_CYCLES(50), .EXIT_CYCLES(10)) u_dut (
    .sys_clk, .rst_b, .supplyAboveThreshold, .resetPin, .supplyBelowBrownout, .brownoutModeCfg,
    .cfgFlashBlank, .adcDone, .adcData, .logCopyDone, .adcStart, .adcSelUpper, .biasEnable,
    .deviceInReset, .initActive, .normalRun, .busAddress, .jtagEnable, .sharedPinsGpio,
    .slowClock, .jtagScanEnable, .fastPwmLowHold, .generalPinsFloat, .brownoutFlag,
    .flashWriteAllowed, .logCopyStart, .runtimeClear);
  strap_adc_model u_straps (.sys_clk, .lat, .adcStart, .adcSelUpper, .biasEnable, .upperCode,
    .lowerCode, .adcDone, .adcData);
  function automatic logic [11:0] mid(input int i);
    return 12'((int'(bnd[i]) + int'(bnd[i + 1])) / 2);
  endfunction : mid
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic run_up(input int adcCyc);
    clears = 0;
    initN = 0;
    rstN = 0;
    for (int i = 0; i < 400 && normalRun !== 1'b1; i++) begin
      @(negedge sys_clk);
      clears += int'(runtimeClear === 1'b1);
      rstN += int'(deviceInReset === 1'b1);
      if (initActive === 1'b1) begin
        initN++;
        chk({fastPwmLowHold, generalPinsFloat}, 12'h3);
      end
    end
    chk(rstN <= 16, 12'h1);
    chk(initN >= 50 + adcCyc && initN <= 51 + adcCyc, 12'h1);
    chk({normalRun, fastPwmLowHold, generalPinsFloat, jtagScanEnable}, 12'h8);
  endtask : run_up
  task automatic boot(input logic [11:0] up, input logic [11:0] lo, input logic blank,
                      input logic mode);
    @(negedge sys_clk);
    rst_b = 1'b0;
    supplyAboveThreshold = 1'b0;
    {upperCode, lowerCode, cfgFlashBlank, brownoutModeCfg} = {up, lo, blank, mode};
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(deviceInReset, 12'h1);
    supplyAboveThreshold = 1'b1;
    run_up(2 * (int'(lat) + 3));
  endtask : boot
  task automatic t_bins();
    for (int i = 0; i < 8; i++) begin
      lat = i[0] ? 4'h7 : 4'h1;
      boot(mid(i), mid(7 - i), 1'b0, 1'b0);
      chk(busAddress, 12'(12 * i + 7 - i));
      chk({jtagEnable, slowClock, sharedPinsGpio}, 12'h1);
      chk({clears[1:0], flashWriteAllowed}, 12'h3);
    end
    $display("test bins done");
  endtask : t_bins
  task automatic t_fallback();
    boot(12'h010, mid(2), 1'b0, 1'b0);
    chk(busAddress, 12'h7E);
    chk({jtagEnable, slowClock, sharedPinsGpio}, 12'h6);
    boot(mid(2), 12'hF00, 1'b0, 1'b0);
    chk(busAddress, 12'h7E);
    chk({jtagEnable, slowClock, sharedPinsGpio}, 12'h6);
    $display("test fallback done");
  endtask : t_fallback
  task automatic t_blank_brownout();
    boot(mid(3), mid(5), 1'b1, 1'b1);
    chk({busAddress, jtagEnable}, {7'h29, 1'b1});
    chk({clears[1:0], flashWriteAllowed}, 12'h0);
    supplyBelowBrownout = 1'b1;
    for (int i = 0; i < 12 && logCopyStart !== 1'b1; i++) @(negedge sys_clk);
    chk({logCopyStart, brownoutFlag}, 12'h3);
    @(negedge sys_clk);
    chk(flashWriteAllowed, 12'h1);
    repeat (2) @(negedge sys_clk);
    logCopyDone = 1'b1;
    @(negedge sys_clk);
    logCopyDone = 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(negedge sys_clk);
      chk({logCopyStart, flashWriteAllowed}, 12'h0);
    end
    supplyBelowBrownout = 1'b0;
    repeat (8) @(negedge sys_clk);
    $display("test blank and brownout done");
  endtask : t_blank_brownout
  task automatic t_pin_reset();
    {upperCode, lowerCode, cfgFlashBlank} = {12'hF00, 12'h010, 1'b0};
    resetPin = 1'b0;
    repeat (150) @(negedge sys_clk);
    chk({deviceInReset, normalRun}, 12'h2);
    resetPin = 1'b1;
    run_up(0);
    chk({busAddress, jtagEnable}, {7'h29, 1'b1});
    supplyAboveThreshold = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(deviceInReset, 12'h1);
    supplyAboveThreshold = 1'b1;
    run_up(0);
    chk({busAddress, jtagEnable}, {7'h29, 1'b1});
    $display("test pin reset done");
  endtask : t_pin_reset
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_b, supplyAboveThreshold, resetPin, supplyBelowBrownout, brownoutModeCfg} = 5'b00100;
    {cfgFlashBlank, logCopyDone, lat, upperCode, lowerCode} = '0;
    t_bins();
    t_fallback();
    t_blank_brownout();
    t_pin_reset();
    wrap_up();
  end
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
endmodule : startup_address_and_reset_control_test
`default_nettype wire

// *** startup_ctrl_pkg.sv ***
// shared constants for the start-up address and reset control block
package startup_ctrl_pkg;
  localparam int CLK_MHZ = 100;
  localparam int RESET_EXIT_US = 1000;
  localparam int RESET_EXIT_CYC = RESET_EXIT_US * CLK_MHZ;
  localparam int INIT_MS = 20;
  localparam int INIT_CYC = INIT_MS * 1000 * CLK_MHZ;
  localparam int RESET_LOW_MIN_NS = 1000;
  localparam int RESET_LOW_MIN_CYC = (RESET_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int ADC_W = 12;
  localparam int BIN_COUNT = 8;
  localparam int ADDR_MULT = 12;
  localparam logic [6:0] ADDR_FALLBACK = 7'h7E;
  localparam logic [ADC_W-1:0] BIN_LOW_MIN = 12'h0C8;
  localparam logic [ADC_W-1:0] BIN_HIGH_MAX = 12'hE00;
  localparam int JTAG_CLK_PCT = 90;
  localparam int GPIO_JTAG_SHARED = 4;
  localparam int JTAG_PIN_COUNT = 6;
endpackage : startup_ctrl_pkg

// *** strap_adc_model.sv ***
// address strap resistors and adc answering conversion requests
`timescale 1ns/100ps
`default_nettype none
module strap_adc_model (
  input wire logic sys_clk,
  input wire logic [3:0] lat,
  input wire logic adcStart,
  input wire logic adcSelUpper,
  input wire logic biasEnable,
  input wire logic [11:0] upperCode,
  input wire logic [11:0] lowerCode,
  output logic adcDone,
  output logic [11:0] adcData
);
  int cnt = -1;
  logic sel = 1'b0;
  initial adcDone = 1'b0;
  initial adcData = 12'hA5A;
  // ************
  // conversion
  // ************
  always @(posedge sys_clk) begin
    adcDone <= 1'b0;
    adcData <= ~adcData;
    if (adcStart === 1'b1) begin
      cnt <= int'(lat);
      sel <= adcSelUpper;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cnt == 0) begin
      cnt <= -1;
      adcDone <= 1'b1;
      adcData <= (biasEnable !== 1'b1) ? 12'hFFF : sel ? upperCode : lowerCode;
    end
  end
endmodule : strap_adc_model
`default_nettype wire
